// File: pkg/reset_source_pkg.sv
package reset_source_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RESET_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_CONFIG        = 8'h04;
  localparam logic [7:0] ADDR_PIN_STATUS    = 8'h08;

  // ----------------------------------------------------------------
  // reset_control_reg fields
  // ----------------------------------------------------------------
  localparam int BIT_POR_FLAG       = 1;
  localparam int BIT_STACK_UNDER    = 2;
  localparam int BIT_STACK_FULL     = 3;

  // ----------------------------------------------------------------
  // config fields
  // ----------------------------------------------------------------
  localparam int BIT_PIN_ENABLE     = 0;
  localparam int BIT_STACK_RST_EN   = 1;
  localparam logic [1:0] CONFIG_RESET = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 10;
  localparam int FILTER_NS          = 200;
  localparam int FILTER_CYCLES      = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_PULSE_CYCLES = 16;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: pkg/pin_filter_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pin_filter_if;
  logic raw_pin;
  logic filtered_low;
  logic level;
  modport owner (input raw_pin, output filtered_low, output level);
  modport user  (output raw_pin, input filtered_low, input level);
endinterface
`default_nettype wire

// File: design/pin_filter.sv
`timescale 1ns/1ps
`default_nettype none
module pin_filter
  import reset_source_pkg::*;
#(
  parameter int FILTER_LEN = FILTER_CYCLES
)(
  input  wire logic    clk,
  input  wire logic    rst_n,
  pin_filter_if.owner  pf
);
  logic [2:0] sync;
  logic [2:0] next_sync;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       low;
  logic       next_low;
  logic       lvl;
  logic       next_lvl;

  always_comb
  begin
    next_sync = {sync[1:0], pf.raw_pin};
    next_lvl  = lvl;
    if (sync[1] == sync[2])
    begin
      next_lvl = sync[2];
    end
    next_cnt = cnt;
    next_low = low;
    // short low pulses never reach the full count
    if (lvl)
    begin
      next_cnt = 8'h00;
      next_low = 1'b0;
    end
    else if (cnt < 8'(FILTER_LEN))
    begin
      next_cnt = cnt + 8'h01;
    end
    else
    begin
      next_low = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync <= 3'h7;
      cnt  <= 8'h00;
      low  <= 1'b0;
      lvl  <= 1'b1;
    end
    else
    begin
      sync <= next_sync;
      cnt  <= next_cnt;
      low  <= next_low;
      lvl  <= next_lvl;
    end
  end

  assign pf.filtered_low = low;
  assign pf.level        = lvl;

  chk_short_pulse_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(low) |-> !$past(lvl, FILTER_LEN))
    else $error("filtered low without a long enough low pulse");
endmodule
`default_nettype wire

// File: design/reset_source_control.sv
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module reset_source_control
  import reset_source_pkg::*;
#(
  parameter int PULSE_LEN = RESET_PULSE_CYCLES
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        power_on_event,
  input  wire logic        external_reset_pin_in,
  output logic             external_reset_pin_out,
  output logic             external_reset_pin_oe,
  output logic             pin_digital_in,
  input  wire logic        stack_full_event,
  input  wire logic        stack_underflow_event,
  output logic             core_reset_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // ----------------------------------------------------------------
  // pin handling
  // ----------------------------------------------------------------
  pin_filter_if pf ();
  assign pf.raw_pin = external_reset_pin_in;

  pin_filter u_filter (
    .clk   (clk),
    .rst_n (rst_n),
    .pf    (pf)
  );

  // input only: an internal reset must never pull the pin down
  assign external_reset_pin_out = 1'b0;
  assign external_reset_pin_oe  = 1'b0;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic       pin_enable;
  logic       next_pin_enable;
  logic       stack_rst_en;
  logic       next_stack_rst_en;
  logic       por_flag;
  logic       next_por_flag;
  logic       stk_full;
  logic       next_stk_full;
  logic       stk_under;
  logic       next_stk_under;
  logic [7:0] pulse_cnt;
  logic [7:0] next_pulse_cnt;
  logic       stack_req;
  logic       next_stack_req;
  logic       pin_digital;
  logic       next_pin_digital;
  logic       aw_held;
  logic       next_aw_held;
  logic       w_held;
  logic       next_w_held;
  logic [7:0] aw_addr;
  logic [7:0] next_aw_addr;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0] w_strb;
  logic [3:0] next_w_strb;
  logic       bvalid;
  logic       next_bvalid;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  logic       rvalid;
  logic       next_rvalid;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0] rresp;
  logic [1:0] next_rresp;
  logic       do_write;
  logic       do_read;
  logic       reset_req;
  logic       rst_meta;
  logic       rst_sync;
  logic       por_sync1;
  logic       por_sync2;
  logic       por_sync3;
  logic       por_level;
  logic       por_seen;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ADDR_RESET_CONTROL) || (a == ADDR_CONFIG) || (a == ADDR_PIN_STATUS);
  endfunction

  // ----------------------------------------------------------------
  // power-on event, three stage sampled
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      por_sync1 <= 1'b0;
      por_sync2 <= 1'b0;
      por_sync3 <= 1'b0;
      por_level <= 1'b0;
    end
    else
    begin
      por_sync1 <= power_on_event;
      por_sync2 <= por_sync1;
      por_sync3 <= por_sync2;
      por_level <= (por_sync2 == por_sync3) ? por_sync3 : por_level;
    end
  end
  // a rise counts only once the last two stages agree, so a glitch is not an event
  assign por_seen = por_sync2 & por_sync3 & ~por_level;

  // ----------------------------------------------------------------
  // bus and flags
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign do_write = aw_held && w_held && !bvalid;
  assign do_read  = s_axi_arvalid && !rvalid;

  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    next_pin_enable   = pin_enable;
    next_stack_rst_en = stack_rst_en;
    next_por_flag     = por_flag;
    next_stk_full     = stk_full;
    next_stk_under    = stk_under;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (w_strb[0] && aw_addr == ADDR_CONFIG)
      begin
        next_pin_enable   = w_data[BIT_PIN_ENABLE];
        next_stack_rst_en = w_data[BIT_STACK_RST_EN];
      end
      if (w_strb[0] && aw_addr == ADDR_RESET_CONTROL)
      begin
        // software may only set the power-on flag
        if (w_data[BIT_POR_FLAG])
        begin
          next_por_flag = 1'b1;
        end
        if (!w_data[BIT_STACK_FULL])
        begin
          next_stk_full = 1'b0;
        end
        if (!w_data[BIT_STACK_UNDER])
        begin
          next_stk_under = 1'b0;
        end
      end
    end
    // hardware sets win over software clears
    if (stack_full_event)
    begin
      next_stk_full = 1'b1;
    end
    if (stack_underflow_event)
    begin
      next_stk_under = 1'b1;
    end
    if (por_seen)
    begin
      next_por_flag  = 1'b0;
      next_stk_full  = 1'b0;
      next_stk_under = 1'b0;
    end
    if (bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    if (rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
    if (do_read)
    begin
      next_rvalid = 1'b1;
      next_rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      next_rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        ADDR_RESET_CONTROL:
        begin
          next_rdata[BIT_POR_FLAG]    = por_flag;
          next_rdata[BIT_STACK_FULL]  = stk_full;
          next_rdata[BIT_STACK_UNDER] = stk_under;
        end
        ADDR_CONFIG:
        begin
          next_rdata[BIT_PIN_ENABLE]   = pin_enable;
          next_rdata[BIT_STACK_RST_EN] = stack_rst_en;
        end
        ADDR_PIN_STATUS:
        begin
          next_rdata[0] = pf.level;
        end
        default:
        begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // reset sources
  // ----------------------------------------------------------------
  always_comb
  begin
    next_pulse_cnt = pulse_cnt;
    if (por_seen)
    begin
      next_pulse_cnt = 8'(PULSE_LEN);
    end
    else if (pulse_cnt != 8'h00)
    begin
      next_pulse_cnt = pulse_cnt - 8'h01;
    end
    // flag registers this cycle, reset follows next cycle
    next_stack_req = stack_rst_en && (stack_full_event || stack_underflow_event);
    // disabled pin is just a data input
    next_pin_digital = pin_enable ? 1'b1 : pf.level;
  end

  // pin low only resets while enabled
  assign reset_req = (pin_enable && pf.filtered_low) || (pulse_cnt != 8'h00) || stack_req;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held      <= 1'b0;
      aw_addr      <= 8'h00;
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      bvalid       <= 1'b0;
      bresp        <= 2'h0;
      rvalid       <= 1'b0;
      rdata        <= 32'h0000_0000;
      rresp        <= 2'h0;
      pin_enable   <= CONFIG_RESET[BIT_PIN_ENABLE];
      stack_rst_en <= CONFIG_RESET[BIT_STACK_RST_EN];
      por_flag     <= 1'b0;
      stk_full     <= 1'b0;
      stk_under    <= 1'b0;
      pulse_cnt    <= 8'h00;
      stack_req    <= 1'b0;
      pin_digital  <= 1'b1;
    end
    else
    begin
      aw_held      <= next_aw_held;
      aw_addr      <= next_aw_addr;
      w_held       <= next_w_held;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      bvalid       <= next_bvalid;
      bresp        <= next_bresp;
      rvalid       <= next_rvalid;
      rdata        <= next_rdata;
      rresp        <= next_rresp;
      pin_enable   <= next_pin_enable;
      stack_rst_en <= next_stack_rst_en;
      por_flag     <= next_por_flag;
      stk_full     <= next_stk_full;
      stk_under    <= next_stk_under;
      pulse_cnt    <= next_pulse_cnt;
      stack_req    <= next_stack_req;
      pin_digital  <= next_pin_digital;
    end
  end

  // ----------------------------------------------------------------
  // merged reset: async assert on rst_n, sync assert for pin/power-on/stack requests, sync release
  // ----------------------------------------------------------------
  // registers are not reset by core_reset_n so flags survive it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else if (reset_req)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end
  assign core_reset_n = rst_sync;

  assign pin_digital_in = pin_digital;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp  = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata  = rdata;
  assign s_axi_rresp  = rresp;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_pin_never_driven: assert property (@(posedge clk) disable iff (!rst_n)
    !external_reset_pin_oe)
    else $error("reset pin output enabled");
  chk_pin_low_resets: assert property (@(posedge clk) disable iff (!rst_n)
    (pin_enable && pf.filtered_low) |=> !core_reset_n)
    else $error("filtered pin low did not reset");
  chk_pin_disabled_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    (!pin_enable && pulse_cnt == 8'h00 && !stack_req && rst_meta) |=> core_reset_n)
    else $error("disabled pin caused reset");
  chk_por_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    por_seen |-> ##2 !core_reset_n [*2])
    else $error("power-on pulse missing");
  chk_por_clears_flag: assert property (@(posedge clk) disable iff (!rst_n)
    por_seen |=> !por_flag)
    else $error("power-on flag not cleared");
  chk_por_flag_only_por: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(por_flag) |-> $past(por_seen))
    else $error("power-on flag cleared by other event");
  chk_stack_reset: assert property (@(posedge clk) disable iff (!rst_n)
    (stack_rst_en && stack_full_event && !por_seen) |=> stk_full ##1 !core_reset_n)
    else $error("stack error did not flag then reset");
  chk_stack_no_reset: assert property (@(posedge clk) disable iff (!rst_n)
    (!stack_rst_en && stack_underflow_event) |=> !stack_req)
    else $error("stack error reset while disabled");
  chk_stack_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(stk_full) |-> $past(por_seen) || $past(do_write))
    else $error("stack full flag dropped by itself");
endmodule
`default_nettype wire

// File: bench/reset_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// reset switch on a line pulled up to the supply
// ------------------------------------------------
module reset_switch_model
(
  input  wire logic clk,
  output logic      pin_level
);
  int unsigned low_left = 0;
  int unsigned req_len = 0;
  int unsigned req_count = 0;
  int unsigned req_seen = 0;
  // a released switch leaves the pull-up in charge, so the line reads high
  assign pin_level = (low_left != 0) ? 1'b0 : 1'b1;
  // the task only posts a request, so the hold counter keeps a single writer
  task automatic press(input int unsigned cycles);
    req_len <= cycles;
    req_count <= req_count + 1;
  endtask
  always @(posedge clk)
  begin
    if (req_count != req_seen)
    begin
      req_seen <= req_count;
      low_left <= req_len;
    end
    else if (low_left != 0)
      low_left <= low_left - 1;
  end
endmodule
`default_nettype wire

// File: bench/reset_source_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module reset_source_control_test;
  import reset_source_pkg::*;
  typedef struct packed
  {
    logic wr; logic [7:0] addr; logic [31:0] data; logic [1:0] resp; logic [31:0] rdata;
  } row_t;
  logic        clk;
  logic        rst_n;
  logic        power_on_event;
  logic        pin_wire;
  logic        model_level;
  logic        pin_out;
  logic        pin_oe;
  logic        pin_digital_in;
  logic        stack_full_event;
  logic        stack_underflow_event;
  logic        core_reset_n;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        oe_bad = 1'b0;
  logic [1:0]  r;
  logic [31:0] d;
  int          n_fail = 0;
  int          n_tests = 0;
  int          cyc = 0;
  // -----------------------------------------------
  // ordinary register cases
  // -----------------------------------------------
  row_t rows [11] = '{
    '{1'b0, ADDR_CONFIG, 32'h0, RESP_OKAY, 32'h3},
    '{1'b0, ADDR_RESET_CONTROL, 32'h0, RESP_OKAY, 32'h0},
    '{1'b0, ADDR_PIN_STATUS, 32'h0, RESP_OKAY, 32'h1},
    '{1'b1, ADDR_RESET_CONTROL, 32'h2, RESP_OKAY, 32'h0},
    '{1'b0, ADDR_RESET_CONTROL, 32'h0, RESP_OKAY, 32'h2},
    '{1'b1, ADDR_RESET_CONTROL, 32'h0, RESP_OKAY, 32'h0},
    '{1'b0, ADDR_RESET_CONTROL, 32'h0, RESP_OKAY, 32'h2},
    '{1'b1, ADDR_RESET_CONTROL, 32'hA, RESP_OKAY, 32'h0},
    '{1'b0, ADDR_RESET_CONTROL, 32'h0, RESP_OKAY, 32'h2},
    '{1'b0, 8'h0C, 32'h0, RESP_SLVERR, 32'h0},
    '{1'b1, 8'h0C, 32'h5, RESP_SLVERR, 32'h0}};
  assign pin_wire = pin_oe ? pin_out : model_level;
  reset_source_control reset_source_control_inst (.clk, .rst_n, .power_on_event,
    .external_reset_pin_in(pin_wire), .external_reset_pin_out(pin_out),
    .external_reset_pin_oe(pin_oe), .pin_digital_in, .stack_full_event,
    .stack_underflow_event, .core_reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  reset_switch_model reset_switch_model_inst (.clk, .pin_level(model_level));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (pin_oe !== 1'b0 || pin_out !== 1'b0)
      oe_bad <= 1'b1;
    cyc++;
    if (cyc == 6000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  // -----------------------------------------------
  // helpers
  // -----------------------------------------------
  task automatic report_and_stop();
    $display("counts: tests=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // waits without a limit of its own: only the cycle ceiling ends a hung transfer
  task automatic axi_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw, w, b;
    b = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b)
    begin
      @(negedge clk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge clk);
      if (aw)
        s_axi_awvalid <= 1'b0;
      if (w)
        s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [1:0] rs, output logic [31:0] v);
    logic ar, rv;
    rv = 1'b0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rv)
    begin
      @(negedge clk);
      ar = s_axi_arvalid & s_axi_arready;
      rv = s_axi_rvalid;
      rs = s_axi_rresp;
      v = s_axi_rdata;
      @(posedge clk);
      if (ar)
        s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask
  // bounded wait for the merged reset to reach a level
  task automatic wait_core(input logic lvl, input int max);
    int n;
    n = 0;
    while (core_reset_n !== lvl && n < max)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check_word({31'h0, core_reset_n}, {31'h0, lvl});
  endtask
  task automatic stay_core(input logic lvl, input int cycles);
    logic ok;
    ok = 1'b1;
    repeat (cycles)
    begin
      @(posedge clk);
      #1;
      if (core_reset_n !== lvl)
        ok = 1'b0;
    end
    check_word({31'h0, ok}, 32'h1);
  endtask
  task automatic pulse_stack(input logic full);
    @(posedge clk);
    stack_full_event <= full;
    stack_underflow_event <= ~full;
    @(posedge clk);
    stack_full_event <= 1'b0;
    stack_underflow_event <= 1'b0;
  endtask
  task automatic read_rc(input logic [31:0] exp);
    axi_read(ADDR_RESET_CONTROL, r, d);
    check_word(d, exp);
  endtask
  // -----------------------------------------------
  // main sequence
  // -----------------------------------------------
  initial
  begin
    {rst_n, power_on_event, stack_full_event, stack_underflow_event} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    wait_core(1'b1, 10);
    $display("test reset done");
    foreach (rows[i])
    begin
      if (rows[i].wr)
        axi_write(rows[i].addr, rows[i].data, r);
      else
        axi_read(rows[i].addr, r, d);
      check_word({30'h0, r}, {30'h0, rows[i].resp});
      if (!rows[i].wr)
        check_word(d, rows[i].rdata);
    end
    $display("test register table done");
    pulse_stack(1'b1);
    wait_core(1'b0, 4);
    wait_core(1'b1, 40);
    read_rc(32'hA);
    axi_write(ADDR_RESET_CONTROL, 32'h2, r);
    read_rc(32'h2);
    $display("test stack reset done");
    axi_write(ADDR_CONFIG, 32'h1, r);
    pulse_stack(1'b0);
    stay_core(1'b1, 20);
    read_rc(32'h6);
    $display("test stack flag only done");
    reset_switch_model_inst.press(5);
    stay_core(1'b1, 30);
    reset_switch_model_inst.press(40);
    wait_core(1'b0, 32);
    wait_core(1'b1, 60);
    $display("test pin reset done");
    axi_write(ADDR_CONFIG, 32'h0, r);
    reset_switch_model_inst.press(40);
    stay_core(1'b1, 30);
    check_word({31'h0, pin_digital_in}, 32'h0);
    axi_read(ADDR_PIN_STATUS, r, d);
    check_word(d, 32'h0);
    repeat (20) @(posedge clk);
    $display("test pin as input done");
    pulse_stack(1'b1);
    @(posedge clk);
    power_on_event <= 1'b1;
    wait_core(1'b0, 10);
    stay_core(1'b0, RESET_PULSE_CYCLES - 1);
    power_on_event <= 1'b0;
    wait_core(1'b1, 40);
    read_rc(32'h0);
    $display("test power-on done");
    @(posedge clk);
    rst_n <= 1'b0;
    #1;
    check_word({31'h0, core_reset_n}, 32'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    #1;
    check_word({31'h0, core_reset_n}, 32'h0);
    wait_core(1'b1, 4);
    check_word({31'h0, oe_bad}, 32'h0);
    $display("test async reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
